// ### rtl/clock_select_pkg.sv
/*
  Constants shared by the system clock select/divide block and its internal
  oscillator model: register addresses, field positions, reset values, codes.
  Assumes an 8-bit special function register port on one 125 MHz clock.
*/
`default_nettype none
package clock_select_pkg;
  // register addresses on the sfr port
  localparam logic [7:0] CTRL_ADDR     = 8'hbd;
  localparam logic [7:0] TRIM_ADDR     = 8'hbf;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'ha9;
  // clock select register fields
  localparam int RDY_BIT  = 7;
  localparam int DIV_LSB  = 4;
  localparam int RSVD_BIT = 3;
  localparam int SEL_LSB  = 0;
  // internal oscillator control fields
  localparam int OSC_ON_BIT   = 7;
  localparam int SETTLED_BIT  = 6;
  localparam int SPREAD_BIT   = 3;
  localparam int PRESCALE_LSB = 0;
  // source codes
  localparam logic [2:0] SRC_INTERNAL = 3'h0;
  localparam logic [2:0] SRC_EXTERNAL = 3'h1;
  // reset values
  localparam logic [2:0] SEL_RESET      = SRC_INTERNAL;
  localparam logic [2:0] DIV_RESET      = 3'h0;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic       OSC_ON_RESET   = 1'b1;
  localparam logic       SPREAD_RESET   = 1'b0;
  localparam logic [7:0] TRIM_RESET     = 8'hdf;  // lands near 24.5 MHz
  // oscillator model: phase increment per 8 ns clock
  localparam logic [15:0] INC_FAST      = 16'h4e20;
  localparam int          INC_TRIM_SHIFT = 5;
  localparam int          DITHER_SHIFT   = 9;     // one step ~0.2 percent
  localparam logic [3:0]  STEP_LAST      = 4'hb;  // 12 steps x 32 = 384 cycles
  localparam logic [4:0]  STEP_CYCLES_LAST = 5'h1f;
  localparam logic [7:0]  APPLY_LIMIT    = 8'h80;
endpackage : clock_select_pkg
`default_nettype wire

// ### rtl/int_osc_model.sv
/*
  Digital model of the trimmable internal oscillator with triangle dithering.
  Emits one-cycle ticks at the oscillator rate; assumes a 125 MHz clock well
  above that rate so every oscillator edge maps to a distinct clock cycle.
*/
`default_nettype none
module int_osc_model
  import clock_select_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // controls
  input  wire logic       osc_on,
  input  wire logic       spread_on,
  input  wire logic [7:0] trim,
  // oscillator edge
  output var  logic       osc_tick
);
  import clock_select_pkg::*;

  typedef struct packed {
    logic [15:0] acc;
    logic [3:0]  step_idx;
    logic [4:0]  step_cnt;
    logic        tick;
  } osc_state_type;

  osc_state_type s_q;
  osc_state_type s_d;
  logic [15:0]   base_inc;
  logic [15:0]   dither;
  logic [15:0]   step_amt;
  logic [15:0]   incr;
  logic [16:0]   sum;
  logic [1:0]    mag;
  logic          neg;

  // larger trim, smaller increment, longer period
  assign base_inc = INC_FAST - ({8'h00, trim} << INC_TRIM_SHIFT);
  assign dither   = base_inc >> DITHER_SHIFT;

  // triangle: 0 1 2 3 2 1 0 -1 -2 -3 -2 -1, each held 32 ticks
  always_comb begin
    unique case (s_q.step_idx)
      4'h1, 4'h5: begin mag = 2'h1; neg = 1'b0; end
      4'h2, 4'h4: begin mag = 2'h2; neg = 1'b0; end
      4'h3:       begin mag = 2'h3; neg = 1'b0; end
      4'h7, 4'hb: begin mag = 2'h1; neg = 1'b1; end
      4'h8, 4'ha: begin mag = 2'h2; neg = 1'b1; end
      4'h9:       begin mag = 2'h3; neg = 1'b1; end
      default:    begin mag = 2'h0; neg = 1'b0; end
    endcase
  end

  // peak of three steps stays below the 0.75 percent band
  always_comb begin
    unique case (mag)
      2'h0: step_amt = 16'h0000;
      2'h1: step_amt = dither;
      2'h2: step_amt = dither << 1;
      2'h3: step_amt = dither + (dither << 1);
    endcase
    incr = neg ? base_inc - step_amt : base_inc + step_amt;
    sum  = {1'b0, s_q.acc} + {1'b0, incr};
  end

  // phase accumulator and dither stepping
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (osc_on) begin
      s_d.acc  = sum[15:0];
      s_d.tick = sum[16];
    end
    if (!spread_on) begin
      s_d.step_idx = 4'h0;
      s_d.step_cnt = 5'h00;
    end else if (osc_on && sum[16]) begin
      s_d.step_cnt = s_q.step_cnt + 5'h01;
      if (s_q.step_cnt == STEP_CYCLES_LAST) begin
        s_d.step_idx = (s_q.step_idx == STEP_LAST) ? 4'h0 : s_q.step_idx + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign osc_tick = s_q.tick;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_osc_halted: assert property (!osc_on |=> !osc_tick)
    else $error("oscillator ticked while disabled");
  a_step_cadence: assert property ($changed(s_q.step_idx) && $past(spread_on)
      |-> osc_tick && $past(s_q.step_cnt) == STEP_CYCLES_LAST)
    else $error("dither step changed off the 32-cycle boundary");
  a_dither_idle: assert property (!spread_on |=> s_q.step_idx == 4'h0)
    else $error("dither active with spread disabled");
  a_dither_range: assert property (s_q.step_idx <= STEP_LAST
      && incr <= base_inc + dither + (dither << 1) && incr + dither + (dither << 1) >= base_inc)
    else $error("dither outside triangle bounds");
endmodule // int_osc_model
`default_nettype wire

// ### rtl/system_clock_select_divide.sv
/*
  System clock source select, internal oscillator post-scaler and 1..128
  power-of-two divider with registers on an 8-bit sfr port. Produces a
  one-cycle core clock tick per divided clock edge. Assumes the external
  oscillator pin is asynchronous and far slower than the 125 MHz clock.
*/
`default_nettype none
module system_clock_select_divide
  import clock_select_pkg::*;
#(
  parameter logic [7:0] TRIM_FACTORY = clock_select_pkg::TRIM_RESET
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output var  logic [7:0] sfr_rdata,
  // external oscillator pin
  input  wire logic       ext_osc_pin,
  // divided core clock
  output var  logic       core_clock_tick,
  output var  logic [2:0] core_source_active
);
  import clock_select_pkg::*;

  typedef struct packed {
    logic [2:0] sel_req;
    logic [2:0] div_req;
    logic [2:0] div_app;
    logic       rdy;
    logic       osc_on;
    logic       spread;
    logic [1:0] prescale;
    logic [7:0] trim;
    logic [1:0] ext_sync;
    logic       ext_prev;
    logic [2:0] pre_cnt;
    logic [2:0] active;
    logic       seen_old;
    logic       seen_new;
    logic [6:0] div_cnt;
    logic       core_tick;
    logic [7:0] rdata;
  } clk_state_type;

  clk_state_type s_q;
  clk_state_type s_d;
  logic          int_tick;
  logic          pre_tick;
  logic          ext_tick;
  logic [2:0]    pre_mask;
  logic [6:0]    div_mask;
  logic [2:0]    target;
  logic          old_tick;
  logic          new_tick;
  logic          switch_now;
  logic          src_tick;
  logic          boundary;
  logic          ctrl_wr;

  int_osc_model u_osc (
    .clock     (clock),
    .rst       (rst),
    .osc_on    (s_q.osc_on),
    .spread_on (s_q.spread),
    .trim      (s_q.trim),
    .osc_tick  (int_tick)
  );

  // post-scaler: 00 /8, 01 /4, 10 /2, 11 /1
  assign pre_mask = 3'h7 >> s_q.prescale;
  assign pre_tick = int_tick && ((s_q.pre_cnt & pre_mask) == pre_mask);
  // external edge seen only after the second sync stage
  assign ext_tick = s_q.ext_sync[1] && !s_q.ext_prev;

  // reserved codes leave the running source alone
  assign target = (s_q.sel_req == SRC_INTERNAL || s_q.sel_req == SRC_EXTERNAL) ? s_q.sel_req
                                                                              : s_q.active;
  assign old_tick = (s_q.active == SRC_EXTERNAL) ? ext_tick : pre_tick;
  assign new_tick = (target == SRC_EXTERNAL) ? ext_tick : pre_tick;
  // wait for an edge of both sources, i.e. one period of the slower
  assign switch_now = (target != s_q.active) && (s_q.seen_old || old_tick) && (s_q.seen_new || new_tick);
  assign src_tick   = old_tick && !switch_now;

  // boundary of the running division: new value only lands here, no runt pulse
  assign div_mask = 7'h7f >> (3'h7 - s_q.div_app);
  assign boundary = src_tick && ((s_q.div_cnt & div_mask) == div_mask);
  assign ctrl_wr  = sfr_wr && sfr_addr == CTRL_ADDR;

  // next state
  always_comb begin
    s_d           = s_q;
    s_d.core_tick = boundary;
    s_d.ext_sync  = {s_q.ext_sync[0], ext_osc_pin};
    s_d.ext_prev  = s_q.ext_sync[1];
    if (int_tick) begin
      s_d.pre_cnt = s_q.pre_cnt + 3'h1;
    end
    // source switchover
    if (target == s_q.active) begin
      s_d.seen_old = 1'b0;
      s_d.seen_new = 1'b0;
    end else if (switch_now) begin
      s_d.active   = target;
      s_d.seen_old = 1'b0;
      s_d.seen_new = 1'b0;
      s_d.div_cnt  = 7'h00;
    end else begin
      s_d.seen_old = s_q.seen_old || old_tick;
      s_d.seen_new = s_q.seen_new || new_tick;
    end
    // divider and applied flag
    if (boundary) begin
      s_d.div_cnt = 7'h00;
      s_d.div_app = s_q.div_req;
      s_d.rdy     = 1'b1;
    end else if (src_tick) begin
      s_d.div_cnt = s_q.div_cnt + 7'h01;
    end
    // register writes; a divide change outranks a boundary that applied the old value
    if (ctrl_wr) begin
      s_d.sel_req = sfr_wdata[SEL_LSB +: 3];
      s_d.div_req = sfr_wdata[DIV_LSB +: 3];
      if (sfr_wdata[DIV_LSB +: 3] != s_q.div_req) begin
        s_d.rdy = 1'b0;
      end
    end
    if (sfr_wr && sfr_addr == TRIM_ADDR) begin
      s_d.trim = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == OSC_CTRL_ADDR) begin
      s_d.osc_on   = sfr_wdata[OSC_ON_BIT];
      s_d.spread   = sfr_wdata[SPREAD_BIT];
      s_d.prescale = sfr_wdata[PRESCALE_LSB +: 2];
    end
    // registered read data, zero for unmapped addresses
    if (sfr_rd) begin
      unique case (sfr_addr)
        CTRL_ADDR:     s_d.rdata = {s_q.rdy, s_q.div_req, 1'b0, s_q.sel_req};
        TRIM_ADDR:     s_d.rdata = s_q.trim;
        OSC_CTRL_ADDR: s_d.rdata = {s_q.osc_on, s_q.osc_on, 2'b00, s_q.spread, 1'b0, s_q.prescale};
        default:       s_d.rdata = 8'h00;
      endcase
    end
  end

  // state register; trim strap value comes in as a constant parameter
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q          <= '0;
      s_q.sel_req  <= SEL_RESET;
      s_q.active   <= SEL_RESET;
      s_q.div_req  <= DIV_RESET;
      s_q.div_app  <= DIV_RESET;
      s_q.osc_on   <= OSC_ON_RESET;
      s_q.spread   <= SPREAD_RESET;
      s_q.prescale <= PRESCALE_RESET;
      s_q.trim     <= TRIM_FACTORY;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata          = s_q.rdata;
  assign core_clock_tick    = s_q.core_tick;
  assign core_source_active = s_q.active;

  // helper: source ticks spent waiting for a pending division
  logic [7:0] wait_ticks_q;
  always_ff @(posedge clock) begin
    if (rst || s_q.rdy) begin
      wait_ticks_q <= 8'h00;
    end else if (src_tick && wait_ticks_q != 8'hff) begin
      wait_ticks_q <= wait_ticks_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence div_change_write;
    ctrl_wr && sfr_wdata[6:4] != s_q.div_req;
  endsequence
  // flag low in a cycle with no boundary: nothing may raise it
  sequence flag_low_no_boundary;
    !s_q.rdy && !boundary;
  endsequence

  a_flag_clears: assert property (div_change_write |=> !s_q.rdy && s_q.div_req == $past(sfr_wdata[6:4]))
    else $error("divide change did not clear ready flag");
  a_apply_bound: assert property (wait_ticks_q <= APPLY_LIMIT)
    else $error("division took over 128 source cycles to apply");
  a_flag_means_applied: assert property (s_q.rdy && !$past(ctrl_wr) |-> s_q.div_app == s_q.div_req)
    else $error("ready flag set with division not applied");
  a_flag_sets: assert property (!s_q.rdy && boundary && !ctrl_wr |=> s_q.rdy && s_q.div_app == $past(s_q.div_req))
    else $error("boundary did not set ready flag");
  a_div1_pass: assert property (s_q.div_app == 3'h0 && src_tick |=> core_clock_tick)
    else $error("divide-by-1 dropped a source edge");
  a_tick_spacing: assert property (boundary && s_q.div_app == 3'h1 && $past(s_q.div_app) == 3'h1
      |-> !core_clock_tick && s_q.div_cnt == 7'h01)
    else $error("divide-by-2 produced back-to-back edges");
  a_reserved_zero: assert property (sfr_rd && sfr_addr == CTRL_ADDR |=> sfr_rdata[3] == 1'b0)
    else $error("reserved clock select bit read non-zero");
  a_source_legal: assert property (core_source_active == SRC_INTERNAL || core_source_active == SRC_EXTERNAL)
    else $error("reserved source code became active");
  a_reset_internal: assert property ($fell(rst) |-> core_source_active == SRC_INTERNAL && s_q.prescale == 2'h0)
    else $error("reset did not select internal source at divide-by-8");
  a_switch_edges: assert property ($changed(core_source_active) |-> $past(s_q.seen_new || new_tick))
    else $error("source switched before an edge of the new source");
  a_prescale_map: assert property (s_q.prescale == 2'h3 && int_tick |-> pre_tick)
    else $error("post-scaler code 11 did not pass every edge");
  // clear beats set on a shared cycle, so the flag can only rise at a boundary
  a_flag_only_boundary: assert property (flag_low_no_boundary |=> !s_q.rdy)
    else $error("ready flag rose without a divider boundary");
  a_flag_readback: assert property (sfr_rd && sfr_addr == CTRL_ADDR
      |=> sfr_rdata[RDY_BIT] == $past(s_q.rdy))
    else $error("ready flag read back wrong");
  a_switch_restart: assert property (switch_now |=> s_q.div_cnt == 7'h00 && !core_clock_tick)
    else $error("source switch let a core tick through");
endmodule // system_clock_select_divide
`default_nettype wire

// ### bench/tb.sv
/*
  Self-checking bench for the system clock select/divide block: register
  access on the sfr port, divider timing on the external source, post-scaler,
  trim and spread behaviour of the internal oscillator.
  Assumes the clock_select_pkg package is compiled first.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_select_pkg::*;

  // design connections
  logic       clock;
  logic       rst;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic       ext_osc_pin;
  logic       core_clock_tick;
  logic [2:0] core_source_active;
  int         errors;
  int         compares;
  int         cyc;
  int         c[4];
  int         n0;
  int         n1;
  int         g;
  int         t0;
  logic [7:0] v;

  system_clock_select_divide u_dut (
    .clock              (clock),
    .rst                (rst),
    .sfr_addr           (sfr_addr),
    .sfr_wr             (sfr_wr),
    .sfr_wdata          (sfr_wdata),
    .sfr_rd             (sfr_rd),
    .sfr_rdata          (sfr_rdata),
    .ext_osc_pin        (ext_osc_pin),
    .core_clock_tick    (core_clock_tick),
    .core_source_active (core_source_active)
  );

  // 125 MHz clock and a cycle counter for timing checks
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  // external source: period of exactly 10 clocks so divided gaps are exact
  initial begin
    ext_osc_pin = 1'b0;
    forever begin
      repeat (5) @(posedge clock);
      #1 ext_osc_pin = ~ext_osc_pin;
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic hang(input string msg);
    errors++;
    $display("CHECK FAILED %0t %s", $time, msg);
    report_and_stop();
  endtask

  // one write: strobe held for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1 sfr_wr = 1'b0;
  endtask

  // one read: data sampled a full cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1 sfr_rd = 1'b0;
    @(posedge clock);
    #1 d = sfr_rdata;
  endtask

  task automatic wait_tick();
    for (int k = 0; k < 3000; k++) begin
      @(posedge clock);
      #1;
      if (core_clock_tick === 1'b1) return;
    end
    hang("no core tick");
  endtask

  task automatic count_ticks(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (core_clock_tick === 1'b1) cnt++;
    end
  endtask

  // poll the applied flag; returns cycles spent
  task automatic wait_flag(output int spent);
    logic [7:0] r;
    spent = cyc;
    for (int k = 0; k < 800; k++) begin
      rd(CTRL_ADDR, r);
      if (r[RDY_BIT] === 1'b1) begin
        spent = cyc - spent;
        return;
      end
    end
    hang("divider flag never set");
  endtask

  task automatic wait_src(input logic [2:0] s);
    for (int k = 0; k < 200; k++) begin
      @(posedge clock);
      #1;
      if (core_source_active === s) return;
    end
    hang("source switch missing");
  endtask

  task automatic do_reset();
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
  endtask

  initial begin
    errors = 0;
    compares = 0;
    cyc = 0;
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    // reset values and reserved bits
    chk({5'h00, core_source_active}, 8'h00, "source after reset");
    rd(TRIM_ADDR, v);
    chk(v, TRIM_RESET, "trim reset");
    rd(OSC_CTRL_ADDR, v);
    chk(v, 8'hc0, "osc ctrl reset");
    wr(CTRL_ADDR, 8'h08);
    rd(CTRL_ADDR, v);
    chk(v & 8'h7f, 8'h00, "reserved bit reads zero");
    wr(8'hbe, 8'h55);
    rd(8'hbe, v);
    chk(v, 8'h00, "unmapped read");
    wr(OSC_CTRL_ADDR, 8'hff);
    rd(OSC_CTRL_ADDR, v);
    chk(v, 8'hcb, "osc ctrl writable bits");
    // post-scaler codes on the internal source, divide-by-1
    for (int p = 0; p < 4; p++) begin
      wr(OSC_CTRL_ADDR, 8'h80 | 8'(p));
      repeat (20) @(posedge clock);
      count_ticks(2000, c[p]);
    end
    for (int p = 0; p < 3; p++) begin
      n0 = c[p] * (8 >> p) - c[3];
      chk(8'(n0 >= -16 && n0 <= 16 && c[p] > 0), 8'h01, "post-scale ratio");
    end
    // trim extremes: zero fastest, all ones slowest
    wr(TRIM_ADDR, 8'h00);
    count_ticks(2000, n0);
    wr(TRIM_ADDR, 8'hff);
    count_ticks(2000, n1);
    chk(8'(n0 > n1), 8'h01, "trim direction");
    wr(TRIM_ADDR, TRIM_RESET);
    // spread keeps the average rate inside the deviation band
    count_ticks(3920, n0);
    wr(OSC_CTRL_ADDR, 8'h8b);
    count_ticks(3920, n1);
    chk(8'((n1 - n0) * 100 <= n0 + 200 && (n0 - n1) * 100 <= n0 + 200), 8'h01, "spread rate");
    // oscillator off: no ticks and settled flag follows
    wr(OSC_CTRL_ADDR, 8'h03);
    rd(OSC_CTRL_ADDR, v);
    chk(v, 8'h03, "osc off readback");
    count_ticks(300, n0);
    chk(8'(n0), 8'h00, "no ticks with osc off");
    wr(OSC_CTRL_ADDR, 8'h83);
    // switch to the external source at divide-by-128
    wr(CTRL_ADDR, 8'h71);
    wait_src(SRC_EXTERNAL);
    wait_flag(g);
    // each step: write just after a boundary, flag drops, then rises in bound
    for (int d = 6; d >= 0; d--) begin
      wait_tick();
      t0 = cyc;
      wr(CTRL_ADDR, {1'b0, 3'(d), 4'h1});
      rd(CTRL_ADDR, v);
      chk(v, {1'b0, 3'(d), 4'h1}, "flag clear after divide change");
      wait_flag(g);
      chk(8'(cyc - t0 <= 1330), 8'h01, "divide applied late");
      wait_tick();
      t0 = cyc;
      wait_tick();
      chk(8'((cyc - t0) == (10 << d)), 8'h01, "divided gap");
    end
    // reserved source code keeps the running source
    wr(CTRL_ADDR, 8'h02);
    repeat (40) @(posedge clock);
    #1 chk({5'h00, core_source_active}, 8'h01, "reserved source ignored");
    rd(CTRL_ADDR, v);
    chk(v & 8'h0f, 8'h02, "reserved code stored");
    wr(CTRL_ADDR, 8'h01);
    wait_src(SRC_EXTERNAL);
    wait_flag(g);
    // reset in mid-run returns to the internal source
    do_reset();
    chk({5'h00, core_source_active}, 8'h00, "source after mid reset");
    rd(CTRL_ADDR, v);
    chk(v & 8'h7f, 8'h00, "ctrl after mid reset");
    wr(CTRL_ADDR, 8'h01);
    wait_src(SRC_EXTERNAL);
    wr(CTRL_ADDR, 8'h00);
    wait_src(SRC_INTERNAL);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
